// *** ascond_pkg.sv ***
// constants for the converter sample conditioning block
// assumes registers are written over the serial configuration port as address/data byte writes
// Operation
// - offset loop runs when enable bit set
// - enable is bit 6 at 0x53; zero disables
// - gain trim bits 7:4 at 0x55, 0.5 dB steps
// - gain trim resets to code 0000
// - loop constant bits 3:0 at 0x55, 256k doubling
// - pattern select bits 2:0 at 0x62
// - user pattern low 0x51, high 0x52
// - converged level is mid-code without pedestal
// - signed pedestal bits 5:0 at 0x63 added
package ascond_pkg;
    localparam logic [7:0] ADDR_USER_LOW   = 8'h51;   // user pattern low byte
    localparam logic [7:0] ADDR_USER_HIGH  = 8'h52;   // user pattern high six bits
    localparam logic [7:0] ADDR_OFFSET_EN  = 8'h53;   // offset correction enable
    localparam logic [7:0] ADDR_GAIN_LOOP  = 8'h55;   // gain_and_loop_constant
    localparam logic [7:0] ADDR_PAT_SEL    = 8'h62;   // output_pattern_select
    localparam logic [7:0] ADDR_LVL_SHIFT  = 8'h63;   // convergence_level_shift
    localparam int         OFFSET_EN_BIT   = 6;       // enable bit position
    localparam int         GAIN_LSB        = 4;       // gain trim field low bit
    localparam logic [3:0] GAIN_RESET      = 4'h0;    // no added gain after reset
    localparam logic [3:0] GAIN_MAX_CODE   = 4'hc;    // 6 dB
    localparam logic [3:0] TC_MAX_CODE     = 4'hb;    // 512M cycles
    localparam int         TC_BASE_LOG2    = 18;      // 256k cycles = 2^18
    localparam logic [2:0] PAT_NORMAL      = 3'h0;    // converter data
    localparam logic [2:0] PAT_ZEROS       = 3'h1;    // all zeros
    localparam logic [2:0] PAT_ONES        = 3'h2;    // all ones
    localparam logic [2:0] PAT_TOGGLE      = 3'h3;    // toggle pattern
    localparam logic [2:0] PAT_RAMP        = 3'h4;    // digital ramp
    localparam logic [2:0] PAT_USER        = 3'h5;    // user pattern
    localparam logic [13:0] TOGGLE_WORD    = 14'h2aaa; // first toggle word
    localparam int         ACC_FRAC        = 30;      // fraction bits of offset estimate
endpackage

// *** ascond_top.sv ***
// converter sample conditioning: offset loop, fine gain, test patterns
// assumes samples arrive offset binary, one per CLK_SYS, and config writes are single-cycle strobes
`timescale 1ns/100ps
module ascond_top import ascond_pkg::*; #(
    parameter int DW = 14                    // sample width
) (
    input  wire logic          CLK_SYS,      // sample clock
    input  wire logic          RESETN,       // configuration reset, active low
    input  wire logic          CFG_WR,       // register write strobe
    input  wire logic [7:0]    CFG_ADDR,     // register address
    input  wire logic [7:0]    CFG_WDATA,    // register write data
    output logic      [7:0]    CFG_RDATA,    // read data for CFG_ADDR
    input  wire logic [DW-1:0] ADC_DATA,     // raw converter sample
    output logic      [DW-1:0] DOUT          // conditioned output word
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0]    user_low_reg;             // user pattern low byte
    logic [5:0]    user_high_reg;            // user pattern high bits
    logic          ofs_en_reg;               // offset loop enable
    logic          ofs_run_reg;              // loop was enabled last cycle, estimate seeded
    logic [3:0]    gain_reg;                 // fine gain code
    logic [3:0]    tc_reg;                   // loop time constant code
    logic [2:0]    pat_reg;                  // pattern select
    logic [5:0]    shift_reg;                // signed pedestal
    logic [DW-1:0] gen_reg;                  // ramp/toggle generator
    logic signed [DW+ACC_FRAC+1:0] acc_reg;  // offset estimate, fixed point
    logic [DW-1:0] dout_reg;                 // output register
    logic [7:0]    rdata_reg;                // read data register

    // register writes; reserved loop codes are stored but clamped in use
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            user_low_reg  <= 8'h00;
            user_high_reg <= 6'h00;
            ofs_en_reg    <= 1'b0;
            gain_reg      <= GAIN_RESET;
            tc_reg        <= 4'h0;
            pat_reg       <= PAT_NORMAL;
            shift_reg     <= 6'h00;
        end else if (CFG_WR) begin
            case (CFG_ADDR)
                ADDR_USER_LOW:  user_low_reg  <= CFG_WDATA;
                ADDR_USER_HIGH: user_high_reg <= CFG_WDATA[5:0];
                ADDR_OFFSET_EN: ofs_en_reg    <= CFG_WDATA[OFFSET_EN_BIT];
                ADDR_GAIN_LOOP: begin
                    gain_reg <= CFG_WDATA[GAIN_LSB+:4];
                    tc_reg   <= CFG_WDATA[3:0];
                end
                ADDR_PAT_SEL:   pat_reg   <= CFG_WDATA[2:0];
                ADDR_LVL_SHIFT: shift_reg <= CFG_WDATA[5:0];
                default: ;
            endcase
        end
    end

    // read back decode
    wire [7:0] rd_mux = (CFG_ADDR == ADDR_USER_LOW)  ? user_low_reg :
                        (CFG_ADDR == ADDR_USER_HIGH) ? {2'b00, user_high_reg} :
                        (CFG_ADDR == ADDR_OFFSET_EN) ? {1'b0, ofs_en_reg, 6'h00} :
                        (CFG_ADDR == ADDR_GAIN_LOOP) ? {gain_reg, tc_reg} :
                        (CFG_ADDR == ADDR_PAT_SEL)   ? {5'h00, pat_reg} :
                        (CFG_ADDR == ADDR_LVL_SHIFT) ? {2'b00, shift_reg} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // offset loop: first-order estimate of the input mean
    // shift = log2 of time constant; reserved codes clamp to the longest
    wire [3:0]  tc_eff  = (tc_reg > TC_MAX_CODE) ? TC_MAX_CODE : tc_reg;
    wire [5:0]  k_shift = 6'(TC_BASE_LOG2) + {2'b00, tc_eff};
    wire signed [DW+ACC_FRAC+1:0] x_fix =
        $signed({2'b00, ADC_DATA, {ACC_FRAC{1'b0}}});
    wire signed [DW+ACC_FRAC+1:0] err = x_fix - acc_reg;
    wire signed [DW+1:0] est = acc_reg[DW+ACC_FRAC+1:ACC_FRAC];   // integer part
    // mid-code as a signed value, the level the loop drives towards
    wire signed [DW+1:0] mid_code = $signed({2'b00, 1'b1, {(DW-1){1'b0}}});
    // target is mid-code plus signed pedestal
    wire signed [DW+1:0] target = mid_code + $signed({{(DW-4){shift_reg[5]}}, shift_reg});
    // enabled: remove the tracked mean and put the target in its place
    wire signed [DW+1:0] corr = ofs_en_reg ? $signed({2'b00, ADC_DATA}) - est + target
                                           : $signed({2'b00, ADC_DATA});

    // estimate update; the first enabled cycle seeds it with the sample so the
    // output starts near the target instead of settling over millions of cycles
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            acc_reg     <= '0;
            ofs_run_reg <= 1'b0;
        end else begin
            ofs_run_reg <= ofs_en_reg;
            if (!ofs_en_reg)
                acc_reg <= '0;
            else if (!ofs_run_reg)
                acc_reg <= x_fix;
            else
                acc_reg <= acc_reg + (err >>> k_shift);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fine gain: multiply by 10^(n*0.5/20) in Q1.10 (table indexed by code)
    function automatic logic [11:0] gain_q10(input logic [3:0] c);
        case (c)
            4'h0: gain_q10 = 12'h400;
            4'h1: gain_q10 = 12'h43d;
            4'h2: gain_q10 = 12'h47d;
            4'h3: gain_q10 = 12'h4c1;
            4'h4: gain_q10 = 12'h509;
            4'h5: gain_q10 = 12'h556;
            4'h6: gain_q10 = 12'h5a6;
            4'h7: gain_q10 = 12'h5fc;
            4'h8: gain_q10 = 12'h657;
            4'h9: gain_q10 = 12'h6b7;
            4'ha: gain_q10 = 12'h71d;
            4'hb: gain_q10 = 12'h789;
            default: gain_q10 = 12'h7fb;   // 6 dB, also for codes above
        endcase
    endfunction
    // gain acts about mid-code so the converged level is kept
    wire signed [DW+1:0] cen  = corr - mid_code;
    wire signed [DW+13:0] prod = cen * $signed({1'b0, gain_q10(gain_reg)});
    wire signed [DW+3:0]  mid  = $signed({4'h0, 1'b1, {(DW-1){1'b0}}});
    wire signed [DW+3:0]  lvl  = prod[DW+13:10] + mid;
    wire [DW-1:0] sat = lvl < 0 ? '0 : (lvl > $signed({4'h0, {DW{1'b1}}}) ? {DW{1'b1}} : lvl[DW-1:0]);

    ////////////////////////////////////////////////////////////////////////////
    // pattern generator and output select
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN)
            gen_reg <= '0;
        else if (pat_reg == PAT_RAMP)
            gen_reg <= gen_reg + 1'b1;
        else if (pat_reg == PAT_TOGGLE)
            gen_reg <= (gen_reg == TOGGLE_WORD[DW-1:0]) ? ~TOGGLE_WORD[DW-1:0]
                                                        : TOGGLE_WORD[DW-1:0];
        else
            gen_reg <= '0;
    end

    wire [13:0] user_word = {user_high_reg, user_low_reg};
    wire [DW-1:0] sel = (pat_reg == PAT_ZEROS)  ? '0 :
                        (pat_reg == PAT_ONES)   ? {DW{1'b1}} :
                        (pat_reg == PAT_TOGGLE) ? gen_reg :
                        (pat_reg == PAT_RAMP)   ? gen_reg :
                        (pat_reg == PAT_USER)   ? user_word[DW-1:0] : sat;

    // output and read registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            dout_reg  <= '0;
            rdata_reg <= 8'h00;
        end else begin
            dout_reg  <= sel;
            rdata_reg <= rd_mux;
        end
    end
    assign DOUT      = dout_reg;
    assign CFG_RDATA = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_gain_reset;
        @(posedge CLK_SYS) $rose(RESETN) |-> gain_reg == GAIN_RESET;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain not zero after reset");
    property p_zeros;
        @(posedge CLK_SYS) disable iff (!RESETN) pat_reg == PAT_ZEROS |=> dout_reg == '0;
    endproperty
    a_zeros: assert property (p_zeros) else $error("zeros pattern wrong");
    property p_ones;
        @(posedge CLK_SYS) disable iff (!RESETN) pat_reg == PAT_ONES |=> dout_reg == {DW{1'b1}};
    endproperty
    a_ones: assert property (p_ones) else $error("ones pattern wrong");
    property p_user;
        @(posedge CLK_SYS) disable iff (!RESETN) pat_reg == PAT_USER |=> dout_reg == $past(user_word[DW-1:0]);
    endproperty
    a_user: assert property (p_user) else $error("user pattern wrong");
    property p_ramp;
        @(posedge CLK_SYS) disable iff (!RESETN)
            pat_reg == PAT_RAMP [*3] |-> gen_reg == DW'($past(gen_reg) + 1'b1);
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp not incrementing");
    property p_toggle;
        @(posedge CLK_SYS) disable iff (!RESETN)
            pat_reg == PAT_TOGGLE [*3] |-> gen_reg == ~$past(gen_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not alternating");
    property p_loop_off;
        @(posedge CLK_SYS) disable iff (!RESETN) !ofs_en_reg |=> acc_reg == '0;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("loop active while disabled");
    property p_en_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
            CFG_WR && CFG_ADDR == ADDR_OFFSET_EN |=> ofs_en_reg == $past(CFG_WDATA[OFFSET_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable bit not stored");
    property p_pass;
        @(posedge CLK_SYS) disable iff (!RESETN)
            pat_reg == PAT_NORMAL && !ofs_en_reg && gain_reg == 4'h0 |=> dout_reg == $past(ADC_DATA);
    endproperty
    a_pass: assert property (p_pass) else $error("normal data not passed");
    // a write to the gain and loop register lands in the gain field
    property p_gain_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
            CFG_WR && CFG_ADDR == ADDR_GAIN_LOOP |=> gain_reg == $past(CFG_WDATA[GAIN_LSB+:4]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain trim not stored");
    // the same write lands in the loop constant field, reserved codes kept
    property p_tc_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
            CFG_WR && CFG_ADDR == ADDR_GAIN_LOOP |=> tc_reg == $past(CFG_WDATA[3:0]);
    endproperty
    a_tc_write: assert property (p_tc_write) else $error("loop constant not stored");
    // pattern select follows its register write
    property p_pat_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
            CFG_WR && CFG_ADDR == ADDR_PAT_SEL |=> pat_reg == $past(CFG_WDATA[2:0]);
    endproperty
    a_pat_write: assert property (p_pat_write) else $error("pattern select not stored");
    // pedestal follows its register write
    property p_shift_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
            CFG_WR && CFG_ADDR == ADDR_LVL_SHIFT |=> shift_reg == $past(CFG_WDATA[5:0]);
    endproperty
    a_shift_write: assert property (p_shift_write) else $error("pedestal not stored");
    // first enabled cycle loads the estimate with the sample
    property p_seed;
        @(posedge CLK_SYS) disable iff (!RESETN)
            ofs_en_reg && !ofs_run_reg |=> acc_reg == $past(x_fix);
    endproperty
    a_seed: assert property (p_seed) else $error("offset estimate not seeded");
    // once the estimate equals the input the output sits at the target level
    property p_converged;
        @(posedge CLK_SYS) disable iff (!RESETN)
            ofs_en_reg && ofs_run_reg && pat_reg == PAT_NORMAL && gain_reg == GAIN_RESET
            && est == $signed({2'b00, ADC_DATA}) |=> dout_reg == $past(target[DW-1:0]);
    endproperty
    a_converged: assert property (p_converged) else $error("converged level wrong");
endmodule

// *** ascond_capture.sv ***
// capture-side model: checks ramp and toggle words arriving from the block
// assumes one output word per clk and a mode code that matches the pattern selected
`timescale 1ns/100ps
module ascond_capture import ascond_pkg::*; (
    input  wire logic        clk,      // sample clock
    input  wire logic        rstn,     // reset, active low
    input  wire logic        en,       // checking armed
    input  wire logic [2:0]  mode,     // expected pattern code
    input  wire logic [13:0] word,     // received word
    output logic      [15:0] good_cnt, // words that matched
    output logic      [15:0] bad_cnt   // words that did not
);
    logic [13:0] prev_reg; // last word seen
    logic        have_reg; // prev_reg is usable
    ////////////////////////////////////////////////////////////////
    // compare each armed word, after the first, with the one before it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            good_cnt <= 16'h0;
            bad_cnt  <= 16'h0;
            have_reg <= 1'b0;
            prev_reg <= 14'h0;
        end else begin
            prev_reg <= word;
            have_reg <= en;
            if (en && have_reg) begin
                if ((mode == PAT_RAMP && word == prev_reg + 14'h1) || (mode == PAT_TOGGLE && word == ~prev_reg)) begin
                    good_cnt <= good_cnt + 16'h1;
                end else begin
                    bad_cnt <= bad_cnt + 16'h1;
                end
            end
        end
    end
endmodule

// *** test_adc_sample_conditioning.sv ***
// testbench: pattern table, register reads, gain, offset loop and pedestal
// assumes the capture model sits on the output word
`timescale 1ns/100ps
module test_adc_sample_conditioning import ascond_pkg::*;;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [13:0] x; logic [13:0] y;} ascond_row_s;
    logic        clk_sys = 0;      // sample clock
    logic        resetn = 0;       // reset, active low
    logic        cfg_wr = 0;       // write strobe
    logic [7:0]  cfg_addr = 0;     // register address
    logic [7:0]  cfg_wdata = 0;    // write data
    logic [7:0]  cfg_rdata;        // read data
    logic [13:0] adc_data = 14'h0; // raw sample
    logic [13:0] dout;             // output word
    logic        cap_en = 0;       // capture checking armed
    logic [2:0]  cap_mode = 0;     // capture expected pattern
    logic [15:0] good_cnt;         // capture matches
    logic [15:0] bad_cnt;          // capture mismatches
    logic [15:0] d0;               // saved output
    int          err_count = 0;    // mismatches
    int          checks = 0;       // comparisons
    ascond_row_s rows[7] = '{'{ADDR_PAT_SEL, 8'h01, 14'h1234, 14'h0000}, '{ADDR_PAT_SEL, 8'h02, 14'h1234, 14'h3fff},
        '{ADDR_USER_LOW, 8'h5a, 14'h1234, 14'h3fff}, '{ADDR_USER_HIGH, 8'h26, 14'h1234, 14'h3fff},
        '{ADDR_PAT_SEL, 8'h05, 14'h1234, 14'h265a}, '{ADDR_PAT_SEL, 8'h00, 14'h1234, 14'h1234},
        '{ADDR_GAIN_LOOP, 8'h07, 14'h0abc, 14'h0abc}};
    ascond_top #(.DW(14)) ascond_top_i (.CLK_SYS(clk_sys), .RESETN(resetn), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
        .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .ADC_DATA(adc_data), .DOUT(dout));
    ascond_capture ascond_capture_i (.clk(clk_sys), .rstn(resetn), .en(cap_en), .mode(cap_mode), .word(dout),
        .good_cnt(good_cnt), .bad_cnt(bad_cnt));
    always #2 clk_sys = ~clk_sys; // 250 MHz
    ////////////////////////////////////////////////////////////////
    // compare and count
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle register write
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask
    // register read, data one cycle after the address
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        cfg_addr <= a;
        repeat (2) @(posedge clk_sys);
        #1 chk({8'h0, cfg_rdata}, {8'h0, e});
    endtask
    task look(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // counts, verdict, end of run
    task stop_test;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog well beyond the expected run
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    // main sequence
    initial begin
        look(3);
        resetn <= 1'b1;
        rd(ADDR_GAIN_LOOP, 8'h00);
        rd(ADDR_LVL_SHIFT, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            adc_data <= rows[i].x;
            look(3);
            #1 chk({2'h0, dout}, {2'h0, rows[i].y});
        end
        rd(ADDR_GAIN_LOOP, 8'h07);
        wr(ADDR_GAIN_LOOP, 8'h0f);
        rd(ADDR_GAIN_LOOP, 8'h0f);
        rd(8'h40, 8'h00);
        // full 6 dB on 100 LSB above mid-code
        wr(ADDR_GAIN_LOOP, 8'hc0);
        adc_data <= 14'h2064;
        look(3);
        #1 chk(16'(dout >= 14'd8387 && dout <= 14'd8396), 16'h1);
        // 3 dB on the same input: 141 LSB above mid-code
        wr(ADDR_GAIN_LOOP, 8'h60);
        look(3);
        #1 chk(16'(dout >= 14'd8332 && dout <= 14'd8334), 16'h1);
        wr(ADDR_GAIN_LOOP, 8'h00);
        // ramp through its wrap, then toggle
        wr(ADDR_PAT_SEL, 8'h04);
        cap_mode <= PAT_RAMP;
        look(3);
        cap_en <= 1'b1;
        look(17000);
        cap_en <= 1'b0;
        wr(ADDR_PAT_SEL, 8'h03);
        cap_mode <= PAT_TOGGLE;
        look(3);
        cap_en <= 1'b1;
        look(50);
        cap_en <= 1'b0;
        look(1);
        #1 chk(bad_cnt, 16'h0);
        chk(16'(good_cnt > 16'd17000), 16'h1);
        // offset loop removes a 100 LSB offset, then pedestal +31 and -32
        wr(ADDR_PAT_SEL, 8'h00);
        adc_data <= 14'h2064;
        wr(ADDR_OFFSET_EN, 8'h40);
        look(8);
        #1 d0 = {2'h0, dout};
        chk(d0, 16'h2000);
        wr(ADDR_LVL_SHIFT, 8'h1f);
        look(3);
        #1 chk(16'({2'h0, dout} - d0), 16'd31);
        wr(ADDR_LVL_SHIFT, 8'h20);
        look(3);
        #1 chk(16'({2'h0, dout} - d0), 16'hffe0);
        // every bit but the enable set: loop off, data passes
        wr(ADDR_OFFSET_EN, 8'hbf);
        adc_data <= 14'h2345;
        look(3);
        #1 chk({2'h0, dout}, 16'h2345);
        // reset in mid-run after a gain write; gain must come back as zero
        wr(ADDR_GAIN_LOOP, 8'h5a);
        resetn <= 1'b0;
        look(2);
        #1 chk({2'h0, dout}, 16'h0);
        look(1);
        resetn <= 1'b1;
        rd(ADDR_GAIN_LOOP, 8'h00);
        rd(ADDR_PAT_SEL, 8'h00);
        stop_test();
    end
endmodule
